// File: tds_sequencer.sv
// ---------------------------------------------------------------------------
// tds_sequencer - transfer delay sequencer with apb register file
// ---------------------------------------------------------------------------
// holds the delay sequencer of a two-source transfer controller.
// assumes source status inputs synchronous to ref_clk_i and a zero-wait
// apb master; switch and relays act on the level outputs.
//
// Function
// - first priority, first failed: override delay waits recovery.
// - second priority: override delay keeps load on failed first source.
// - first priority: transfer delay holds failed first once second up.
// - second priority: transfer delay before return; skip on failure.
// - pre-transfer output on set time before first-to-second move.
// - pre-transfer output kept set time after first-to-second transfer.
// - delayed transition type pauses at centre, both directions.
// - centre pause skipped when departing source lost every phase.
// - second source override delay, mirror of first source override.
// - transfer-to-first delay before return; second failure overrides.
// - pre-transfer output on set time before second-to-first move.
// - pre-transfer output kept set time after second-to-first transfer.
// - generator runs unloaded for cool-down after return, then stops.
// - load shed asserted set time before leaving the priority source.
// - elevator signal before and after each transfer, per direction.
module tds_sequencer #(
   parameter int unsigned TICKS_PER_SEC = tds_pkg::SEC_CYCLES
) (
   input  wire logic        ref_clk_i,             // system clock
   input  wire logic        srst_i,                // sync reset, high
   input  wire logic        psel_i,                // apb select
   input  wire logic        penable_i,             // apb enable
   input  wire logic        pwrite_i,              // apb write
   input  wire logic [11:0] paddr_i,               // apb byte address
   input  wire logic [31:0] pwdata_i,              // apb write data
   output logic      [31:0] prdata_o,              // apb read data
   output logic             pready_o,              // apb ready
   output logic             pslverr_o,             // apb error
   input  wire logic        first_source_ok_i,     // first source acceptable
   input  wire logic        second_source_ok_i,    // second source acceptable
   input  wire logic        first_source_dead_i,   // all first phases missing
   input  wire logic        second_source_dead_i,  // all second phases missing
   output logic             load_on_first_o,       // close on first source
   output logic             load_on_second_o,      // close on second source
   output logic             pre_xfer_o,            // pre/post transfer signal
   output logic             load_shed_o,           // load shed signal
   output logic             elevator_o,            // elevator pre/post signal
   output logic             gen_run_o              // generator run command
);

   localparam int unsigned DW = tds_pkg::DW;

   typedef enum logic [2:0] {
      ST_IDLE, ST_WAIT1, ST_WAIT2, ST_PRE, ST_CTR, ST_POST
   } tds_state_t;

   // ------------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------------
   function automatic logic [DW-1:0] mx(input logic [DW-1:0] a,
                                        input logic [DW-1:0] b);
      mx = (a > b) ? a : b;
   endfunction : mx

   // a setting counts only while its output is configured
   function automatic logic [DW-1:0] en_dly(input logic en,
                                            input logic [DW-1:0] d);
      en_dly = en ? d : '0;
   endfunction : en_dly

   // lead signal: on during the last d seconds of a phase of length len
   function automatic logic lead_on(input logic [DW-1:0] cnt,
                                    input logic [DW-1:0] len,
                                    input logic [DW-1:0] d);
      lead_on = (d != '0) && (cnt >= len - d);
   endfunction : lead_on

   // ------------------------------------------------------------------------
   // register file
   // ------------------------------------------------------------------------
   logic [tds_pkg::CTRL_W-1:0] ctrl_r;
   logic [DW-1:0]              dly_r [tds_pkg::NDLY];
   logic [31:0]                prdata_r;
   logic                       pslverr_r;
   logic [31:0]                status;
   logic                       acc_w;
   logic                       is_dly;
   logic [3:0]                 dly_idx;

   assign is_dly  = (paddr_i >= tds_pkg::DLY_BASE) &&
                    (paddr_i < tds_pkg::DLY_BASE + 12'(4 * tds_pkg::NDLY)) &&
                    (paddr_i[1:0] == 2'h0);
   assign dly_idx = 4'((paddr_i - tds_pkg::DLY_BASE) >> 2);
   assign acc_w   = psel_i && penable_i && pwrite_i;

   // zero-wait slave; read data is captured in the setup cycle
   assign pready_o  = 1'b1;
   assign prdata_o  = prdata_r;
   assign pslverr_o = pslverr_r;

   // writes take effect at the access edge; unmapped writes are dropped
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         ctrl_r <= tds_pkg::CTRL_RST;
         for (int i = 0; i < tds_pkg::NDLY; i++) begin
            dly_r[i] <= tds_pkg::dly_rst(i);
         end
      end else if (acc_w) begin
         if (paddr_i == tds_pkg::CTRL_OFS) begin
            ctrl_r <= pwdata_i[tds_pkg::CTRL_W-1:0];
         end else if (is_dly) begin
            dly_r[dly_idx] <= pwdata_i[DW-1:0];
         end
      end
   end

   // read data and error answer, both settled before the access phase
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (psel_i && !penable_i) begin
         pslverr_r <= !(paddr_i == tds_pkg::CTRL_OFS ||
                        paddr_i == tds_pkg::STAT_OFS || is_dly);
         if (paddr_i == tds_pkg::CTRL_OFS) begin
            prdata_r <= 32'(ctrl_r);
         end else if (paddr_i == tds_pkg::STAT_OFS) begin
            prdata_r <= status;
         end else if (is_dly) begin
            prdata_r <= 32'(dly_r[dly_idx]);
         end else begin
            prdata_r <= 32'h0000_0000;
         end
      end
   end

   // ------------------------------------------------------------------------
   // source decision
   // ------------------------------------------------------------------------
   logic          pos_r;      // 0: load side on first, 1: on second
   tds_state_t    st_r;
   tds_state_t    st_nxt;
   logic [DW-1:0] cnt_r;      // whole seconds spent in the phase
   logic [25:0]   div_r;      // phase prescaler
   logic          tick;
   logic          prio2;
   logic          prio_here;  // load sits on the priority source
   logic          cur_ok;
   logic          oth_ok;
   logic          cur_dead;
   logic          trig;
   logic          two_stage;
   logic [DW-1:0] lim1;
   logic [DW-1:0] lim2;

   assign prio2     = ctrl_r[tds_pkg::C_PRIO2];
   assign prio_here = (pos_r == prio2);
   assign cur_ok    = pos_r ? second_source_ok_i : first_source_ok_i;
   assign oth_ok    = pos_r ? first_source_ok_i  : second_source_ok_i;
   assign cur_dead  = pos_r ? second_source_dead_i : first_source_dead_i;

   // on priority and failed: wait for recovery, then hold for the other
   assign two_stage = prio_here && !cur_ok;
   // leave on failure with the other up, or return to a healthy priority
   assign trig = two_stage || (oth_ok && (!cur_ok || !prio_here));
   // failure uses the override delay; a healthy return the transfer delay
   assign lim1 = !cur_ok ?
                 dly_r[pos_r ? tds_pkg::D_OVR2 : tds_pkg::D_OVR1] :
                 dly_r[pos_r ? tds_pkg::D_X21  : tds_pkg::D_X12];
   assign lim2 = dly_r[pos_r ? tds_pkg::D_X21 : tds_pkg::D_X12];

   // ------------------------------------------------------------------------
   // phase lengths per direction
   // ------------------------------------------------------------------------
   logic          pre_en;
   logic          shed_en;
   logic          elev_en;
   logic [DW-1:0] d_pre;
   logic [DW-1:0] d_post;
   logic [DW-1:0] d_epre;
   logic [DW-1:0] d_epost;
   logic [DW-1:0] d_shed;
   logic [DW-1:0] pre_len;
   logic [DW-1:0] post_len;
   logic          ctr_need;

   assign pre_en  = ctrl_r[tds_pkg::C_PRE_OUT];
   assign shed_en = ctrl_r[tds_pkg::C_SHED_OUT];
   assign elev_en = ctrl_r[tds_pkg::C_ELEV_OUT];

   // unconfigured outputs contribute nothing, so their phase vanishes
   assign d_pre   = en_dly(pre_en,
                    dly_r[pos_r ? tds_pkg::D_PRE21 : tds_pkg::D_PRE12]);
   // post lengths are read after the flip, so pick the old direction
   assign d_post  = en_dly(pre_en,
                    dly_r[pos_r ? tds_pkg::D_POST12 : tds_pkg::D_POST21]);
   assign d_epre  = en_dly(elev_en,
                    dly_r[pos_r ? tds_pkg::D_EPRE21 : tds_pkg::D_EPRE12]);
   assign d_epost = en_dly(elev_en,
                    dly_r[pos_r ? tds_pkg::D_EPST12 : tds_pkg::D_EPST21]);
   assign d_shed  = en_dly(shed_en && prio_here, dly_r[tds_pkg::D_SHED]);
   assign pre_len  = mx(mx(d_pre, d_epre), d_shed);
   assign post_len = mx(d_post, d_epost);

   // centre pause only on the delayed type and while the source lives
   assign ctr_need = ctrl_r[tds_pkg::C_DELAYED] && !cur_dead &&
                     (dly_r[tds_pkg::D_CTR] != '0);

   // ------------------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------------------
   // each wait holds only while its cause holds, else back to idle
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ST_IDLE: begin
            if (trig) st_nxt = ST_WAIT1;
         end
         ST_WAIT1: begin
            if (!trig) st_nxt = ST_IDLE;
            else if (cnt_r >= lim1) begin
               st_nxt = two_stage ? ST_WAIT2 : ST_PRE;
            end
         end
         ST_WAIT2: begin
            if (cur_ok) st_nxt = ST_IDLE;
            else if (oth_ok && cnt_r >= lim2) st_nxt = ST_PRE;
         end
         ST_PRE: begin
            if (!oth_ok) st_nxt = ST_IDLE;
            else if (cnt_r >= pre_len) begin
               st_nxt = ctr_need ? ST_CTR : ST_POST;
            end
         end
         ST_CTR: begin
            if (cnt_r >= dly_r[tds_pkg::D_CTR]) st_nxt = ST_POST;
         end
         ST_POST: begin
            if (cnt_r >= post_len) st_nxt = ST_IDLE;
         end
         default: st_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) st_r <= ST_IDLE;
      else        st_r <= st_nxt;
   end

   // phase timer restarts with its prescaler on each state change
   assign tick = (div_r == 26'(TICKS_PER_SEC - 1));
   always_ff @(posedge ref_clk_i) begin
      if (srst_i || st_nxt != st_r || (st_r == ST_WAIT2 && !oth_ok)) begin
         div_r <= 26'h0000000;
         cnt_r <= '0;
      end else if (tick) begin
         div_r <= 26'h0000000;
         if (cnt_r != {DW{1'b1}}) cnt_r <= cnt_r + 1'b1;
      end else begin
         div_r <= div_r + 1'b1;
      end
   end

   // switch position: open during the centre pause, flip on entering post
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         pos_r            <= 1'b0;
         load_on_first_o  <= 1'b1;
         load_on_second_o <= 1'b0;
      end else if (st_r != ST_POST && st_nxt == ST_POST) begin
         pos_r            <= !pos_r;
         load_on_first_o  <= pos_r;
         load_on_second_o <= !pos_r;
      end else if (st_r == ST_PRE && st_nxt == ST_CTR) begin
         load_on_first_o  <= 1'b0;
         load_on_second_o <= 1'b0;
      end
   end

   // timed signals; post values use the direction just completed
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         pre_xfer_o  <= 1'b0;
         load_shed_o <= 1'b0;
         elevator_o  <= 1'b0;
      end else begin
         pre_xfer_o  <= (st_r == ST_PRE && lead_on(cnt_r, pre_len, d_pre)) ||
                        (st_r == ST_POST && cnt_r < dly_r[pos_r ?
                         tds_pkg::D_POST12 : tds_pkg::D_POST21] && pre_en);
         load_shed_o <= st_r == ST_PRE && lead_on(cnt_r, pre_len, d_shed);
         elevator_o  <= (st_r == ST_PRE && lead_on(cnt_r, pre_len, d_epre)) ||
                        (st_r == ST_POST && cnt_r < dly_r[pos_r ?
                         tds_pkg::D_EPST12 : tds_pkg::D_EPST21] && elev_en);
      end
   end

   // ------------------------------------------------------------------------
   // generator cool-down
   // ------------------------------------------------------------------------
   logic [25:0]   gdiv_r;
   logic [DW-1:0] gcnt_r;
   logic          gtick;
   logic          gen_need;
   logic [DW-1:0] gen_lim;

   // generator feeds the non-priority side; needed while priority is off
   assign gen_need = !prio_here || st_r != ST_IDLE ||
                     !(prio2 ? second_source_ok_i : first_source_ok_i);
   assign gen_lim  = DW'(dly_r[tds_pkg::D_GEN] * tds_pkg::MIN_SECONDS);
   assign gtick    = (gdiv_r == 26'(TICKS_PER_SEC - 1));

   // free-running prescaler: cool-down resolves to within one second
   always_ff @(posedge ref_clk_i) begin
      if (srst_i || gtick) gdiv_r <= 26'h0000000;
      else                 gdiv_r <= gdiv_r + 1'b1;
   end

   // run while needed, then count the unloaded minutes before stopping
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         gen_run_o <= 1'b0;
         gcnt_r    <= '0;
      end else if (!ctrl_r[tds_pkg::C_GEN]) begin
         gen_run_o <= 1'b0;
         gcnt_r    <= '0;
      end else if (gen_need) begin
         gen_run_o <= 1'b1;
         gcnt_r    <= '0;
      end else if (gen_run_o) begin
         if (gcnt_r >= gen_lim) gen_run_o <= 1'b0;
         else if (gtick) gcnt_r <= gcnt_r + 1'b1;
      end
   end

   // ------------------------------------------------------------------------
   // status word
   // ------------------------------------------------------------------------
   assign status = {16'h0000, cnt_r[7:0], st_r, gen_run_o, elevator_o,
                    load_shed_o, pre_xfer_o, pos_r};

endmodule : tds_sequencer

// File: tds_pkg.sv
// ---------------------------------------------------------------------------
// tds_pkg - constants for the transfer delay sequencer
// ---------------------------------------------------------------------------
// holds register offsets, control bit positions, delay slots and defaults.
// assumes a 40 MHz system clock and a 32-bit apb register bus.
package tds_pkg;

   // ------------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------------
   localparam int unsigned CLK_HZ       = 40_000_000;  // system clock rate
   localparam int unsigned SEC_S        = 1;           // one second tick
   localparam int unsigned SEC_CYCLES   = CLK_HZ * SEC_S;
   localparam int unsigned MIN_SECONDS  = 60;          // seconds per minute
   localparam int unsigned DW           = 13;          // delay / count width

   // ------------------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------------------
   localparam logic [11:0] CTRL_OFS   = 12'h000;  // configuration bits
   localparam logic [11:0] STAT_OFS   = 12'h004;  // sequencer status
   localparam logic [11:0] DLY_BASE   = 12'h040;  // first delay register
   localparam int unsigned NDLY       = 15;       // number of delay registers

   // ctrl bit positions
   localparam int unsigned C_PRIO2    = 0;  // 1: second source has priority
   localparam int unsigned C_DELAYED  = 1;  // delayed_transition_type switch
   localparam int unsigned C_GEN      = 2;  // generator in use
   localparam int unsigned C_PRE_OUT  = 3;  // an output is pre-transfer
   localparam int unsigned C_SHED_OUT = 4;  // an output is load shed
   localparam int unsigned C_ELEV_OUT = 5;  // an output is elevator signal
   localparam int unsigned CTRL_W     = 6;
   localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;

   // delay slots; unit is seconds except D_GEN which is minutes
   localparam int unsigned D_OVR1   = 0;   // first source failure override
   localparam int unsigned D_X12    = 1;   // transfer first to second
   localparam int unsigned D_X21    = 2;   // transfer second to first
   localparam int unsigned D_PRE12  = 3;   // pre-transfer first to second
   localparam int unsigned D_POST12 = 4;   // post-transfer first to second
   localparam int unsigned D_PRE21  = 5;   // pre-transfer second to first
   localparam int unsigned D_POST21 = 6;   // post-transfer second to first
   localparam int unsigned D_CTR    = 7;   // centre-off pause
   localparam int unsigned D_OVR2   = 8;   // second source failure override
   localparam int unsigned D_GEN    = 9;   // generator cool-down, minutes
   localparam int unsigned D_SHED   = 10;  // load shed lead time
   localparam int unsigned D_EPRE12 = 11;  // elevator pre first to second
   localparam int unsigned D_EPST12 = 12;  // elevator post first to second
   localparam int unsigned D_EPRE21 = 13;  // elevator pre second to first
   localparam int unsigned D_EPST21 = 14;  // elevator post second to first

   localparam logic [DW-1:0] OVR_RST  = 13'h0002;  // 2 s
   localparam logic [DW-1:0] XFER_RST = 13'h0002;  // 2 s
   localparam logic [DW-1:0] GEN_RST  = 13'h0005;  // 5 min
   localparam logic [DW-1:0] ZERO_RST = 13'h0000;

   // reset value of a delay slot
   function automatic logic [DW-1:0] dly_rst(input int unsigned i);
      case (i)
         D_OVR1, D_OVR2: dly_rst = OVR_RST;
         D_X12, D_X21:   dly_rst = XFER_RST;
         D_GEN:          dly_rst = GEN_RST;
         default:        dly_rst = ZERO_RST;
      endcase
   endfunction : dly_rst

endpackage : tds_pkg

// File: tds_chk.sv
// tds_chk - port assertions for the transfer delay sequencer
// assumes one clock domain; bound to every tds_sequencer below
module tds_chk (
   input wire logic        ref_clk_i,        // clock
   input wire logic        srst_i,           // reset
   input wire logic        psel_i,           // select
   input wire logic        penable_i,        // enable
   input wire logic [11:0] paddr_i,          // address
   input wire logic [31:0] prdata_o,         // read data
   input wire logic        pready_o,         // ready
   input wire logic        pslverr_o,        // error
   input wire logic        load_on_first_o,  // on first
   input wire logic        load_on_second_o, // on second
   input wire logic        pre_xfer_o,       // pre signal
   input wire logic        load_shed_o,      // shed
   input wire logic        elevator_o,       // elevator
   input wire logic        gen_run_o         // generator
);
   // ---------------------------------------------------------------
   // decode of the setup cycle
   // ---------------------------------------------------------------
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   wire       setup = psel_i && !penable_i;
   wire       hole  = (paddr_i[1:0] != 2'h0) || (paddr_i > 12'h078) ||
                      (paddr_i > 12'h004 && paddr_i < 12'h040);
   wire [3:0] sigs  = {gen_run_o, elevator_o, load_shed_o, pre_xfer_o};
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_ready_high: assert property (pready_o) else $error("ready low");
   a_never_both: assert property (
      !(load_on_first_o && load_on_second_o)) else $error("both closed");
   a_reset_pos: assert property (disable iff (1'b0) srst_i |=>
      load_on_first_o && !load_on_second_o && !gen_run_o && !pre_xfer_o)
      else $error("reset state wrong");
   a_hole_err: assert property (setup && hole |=>
      pslverr_o && prdata_o == 32'h0) else $error("unmapped not refused");
   a_map_ok: assert property (setup && !hole |=> !pslverr_o)
      else $error("mapped refused");
   a_ctrl_rsvd: assert property (setup && paddr_i == 12'h000 |=>
      prdata_o[31:6] == 26'h0) else $error("ctrl spare bits set");
   a_dly_rsvd: assert property (setup && !hole && paddr_i >= 12'h040 |=>
      prdata_o[31:13] == 19'h0) else $error("delay spare bits set");
   a_stat_mirror: assert property (setup && paddr_i == 12'h004 |=>
      prdata_o[4:1] == $past(sigs)) else $error("status not outputs");
   a_rdata_hold: assert property (psel_i && penable_i |=>
      $stable(prdata_o)) else $error("read data moved");
endmodule : tds_chk

bind tds_sequencer tds_chk u_tds_chk (.ref_clk_i, .srst_i, .psel_i,
   .penable_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o,
   .load_on_first_o, .load_on_second_o, .pre_xfer_o, .load_shed_o,
   .elevator_o, .gen_run_o);

// File: tds_src_model.sv
// tds_src_model - the two supplies as the monitors report them
// assumes the bench sets each supply up or down at a clock edge
module tds_src_model (
   input  wire logic ref_clk_i,            // clock
   input  wire logic up1_i,                // first supply healthy
   input  wire logic up2_i,                // second supply healthy
   input  wire logic gone1_i,              // first lost every phase
   input  wire logic gone2_i,              // second lost every phase
   output logic      first_source_ok_o,    // first acceptable
   output logic      second_source_ok_o,   // second acceptable
   output logic      first_source_dead_o,  // first fully down
   output logic      second_source_dead_o  // second fully down
);
   // a supply with no phase left is never acceptable; one flop of lag
   // stands in for the monitor's own filtering
   always_ff @(posedge ref_clk_i) begin
      first_source_ok_o    <= up1_i && !gone1_i;
      second_source_ok_o   <= up2_i && !gone2_i;
      first_source_dead_o  <= gone1_i;
      second_source_dead_o <= gone2_i;
   end
endmodule : tds_src_model

// File: tb_top.sv
// tb_top - self-checking bench for the transfer delay sequencer
// assumes a zero-wait apb slave; seconds shortened to T cycles
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int T = 10;  // short second keeps the run small
   logic        ref_clk_i = 1'b0, srst_i = 1'b1, psel_i = 1'b0;
   logic        penable_i = 1'b0, pwrite_i = 1'b0, e, gone2 = 1'b0;
   logic [11:0] paddr_i   = 12'h000;
   logic [31:0] pwdata_i  = 32'h0, prdata_o, q, r;
   logic        up1 = 1'b1, up2 = 1'b1, gone1 = 1'b0, ok1, ok2, dd1, dd2;
   logic        pready_o, pslverr_o, load_on_first_o, load_on_second_o;
   logic        pre_xfer_o, load_shed_o, elevator_o, gen_run_o;
   int          n_errors = 0, total_checks = 0, cyc = 0, n, d0, d1, d3;
   logic [11:0] bad [3] = '{12'h008, 12'h07C, 12'h042};

   tds_sequencer #(.TICKS_PER_SEC(T)) u_tds_sequencer (.ref_clk_i,
      .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .first_source_ok_i(ok1),
      .second_source_ok_i(ok2), .first_source_dead_i(dd1),
      .second_source_dead_i(dd2), .load_on_first_o, .load_on_second_o,
      .pre_xfer_o, .load_shed_o, .elevator_o, .gen_run_o);
   tds_src_model u_tds_src_model (.ref_clk_i, .up1_i(up1), .up2_i(up2),
      .gone1_i(gone1), .gone2_i(gone2), .first_source_ok_o(ok1),
      .second_source_ok_o(ok2), .first_source_dead_o(dd1),
      .second_source_dead_o(dd2));

   // ---------------------------------------------------------------
   // clock, hang guard and shared tasks
   // ---------------------------------------------------------------
   always #12.5 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         print_verdict();
      end
   end
   task automatic print_verdict;
      if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   task automatic chk(input string s, input logic [31:0] x, g);
      total_checks++;
      if (g !== x) begin
         n_errors++;
         $display("Error %s expected %h seen %h", s, x, g);
      end
   endtask : chk
   // a measured wait must land inside the window the delay allows
   task automatic rng(input string s, input int lo, hi, v);
      total_checks++;
      if (v < lo || v > hi) begin
         n_errors++;
         $display("Error %s expected %0d..%0d seen %0d", s, lo, hi, v);
      end
   endtask : rng
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge ref_clk_i);
      psel_i    <= 1'b1;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      do @(posedge ref_clk_i); while (pready_o !== 1'b1);
      q = prdata_o;
      e = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb
   task automatic setd(input int i, input int v);
      apb(1'b1, tds_pkg::DLY_BASE + 12'(4 * i), 32'(v));
   endtask : setd
   task automatic src(input logic a, b, g);
      @(posedge ref_clk_i);
      up1   <= a;
      up2   <= b;
      gone1 <= g && !a;
      gone2 <= g && !b;
   endtask : src
   function automatic logic sel(input int k);
      case (k)
         0: return load_on_second_o;
         1: return load_on_first_o;
         2: return pre_xfer_o;
         default: return gen_run_o;
      endcase
   endfunction : sel
   // sampling on the falling edge keeps clear of the launch edge
   task automatic wt(input int k, input logic v);
      n = 0;
      while (sel(k) !== v && n < 4000) begin
         @(negedge ref_clk_i);
         n++;
      end
   endtask : wt
   function automatic int exp_rst(input int i);
      return (i < 3 || i == 8) ? 2 : (i == 9) ? 5 : 0;
   endfunction : exp_rst

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      n = $urandom(32'hDBF5C70A);
      repeat (5) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      @(negedge ref_clk_i);
      chk("reset outputs", 32'h20, {load_on_first_o, load_on_second_o,
          pre_xfer_o, load_shed_o, elevator_o, gen_run_o});
      for (int i = 0; i < 15; i++) begin
         apb(1'b0, tds_pkg::DLY_BASE + 12'(4 * i), 32'h0);
         chk("delay default", exp_rst(i), q);
      end
      foreach (bad[i]) begin
         apb(1'b0, bad[i], 32'h0);
         chk("unmapped error", 32'h1, {31'h0, e});
      end
      r = $urandom;
      apb(1'b1, tds_pkg::CTRL_OFS, r);
      apb(1'b0, tds_pkg::CTRL_OFS, 32'h0);
      chk("ctrl readback", {26'h0, r[5:0]}, q);
      apb(1'b1, tds_pkg::CTRL_OFS, 32'h0);
      src(1'b0, 1'b1, 1'b0);
      repeat (15) @(posedge ref_clk_i);
      src(1'b1, 1'b1, 1'b0);
      repeat (40) @(negedge ref_clk_i);
      chk("brief loss held", 32'h1, {31'h0, load_on_first_o});
      d0 = $urandom_range(2, 0);
      d1 = $urandom_range(2, 0);
      d3 = $urandom_range(2, 1);
      apb(1'b1, tds_pkg::CTRL_OFS, 32'h3C);
      setd(0, d0);
      setd(1, d1);
      setd(3, d3);
      setd(4, 1);
      setd(10, 1);
      setd(11, 1);
      src(1'b0, 1'b1, 1'b0);
      wt(0, 1'b1);
      rng("forward time", T * (d0 + d1 + d3),
          T * (d0 + d1 + d3) + 10, n);
      chk("signals at move", 32'hF, {28'h0, pre_xfer_o, load_shed_o,
          elevator_o, gen_run_o});
      wt(2, 1'b0);
      rng("post hold", T - 2, T + 4, n);
      setd(2, 1);
      setd(9, 0);
      src(1'b1, 1'b1, 1'b0);
      wt(1, 1'b1);
      rng("return time", T, T + 10, n);
      wt(3, 1'b0);
      rng("cool-down", 0, T + 6, n);
      apb(1'b1, tds_pkg::CTRL_OFS, 32'h02);
      setd(0, 0);
      setd(1, 0);
      setd(2, 0);
      setd(7, 1);
      for (int j = 0; j < 2; j++) begin
         src(1'b0, 1'b1, j[0]);
         wt(1, 1'b0);
         wt(0, 1'b1);
         rng("centre pause", j ? 0 : T, j ? 3 : T + 4,
             n);
         src(1'b1, !j[0], j[0]);
         wt(0, 1'b0);
         wt(1, 1'b1);
         rng("centre return", j ? 0 : T, j ? 3 : T + 4,
             n);
      end
      src(1'b1, 1'b1, 1'b0);
      setd(1, 1);
      apb(1'b1, tds_pkg::CTRL_OFS, 32'h01);
      wt(0, 1'b1);
      rng("second priority", T, T + 12, n);
      src(1'b1, 1'b0, 1'b0);
      wt(1, 1'b1);
      rng("second override", 2 * T, 2 * T + 10, n);
      print_verdict();
   end
endmodule : tb_top
